/* usbepc_regs.sv */
// Endpoint byte-count and FIFO-reset registers behind an AXI4-Lite slave.
// Assumes SIE strobes come from logic on sys_clk; no synchronisers needed.
// Summary of operation
// - High count register shows selected count's top bits
// - Upper count bits read zero, writes ignored
// - Count accesses follow the endpoint select field
// - One reset bit per endpoint, bit seven zero
// - FIFO stays reset while bit set
// - Count equals bytes received after data PID
`timescale 1ns/1ps
module usbepc_regs
	import usbepc_pkg::*;
(
	input  wire logic                    sys_clk,          // System clock, 200 MHz
	input  wire logic                    rst,              // Synchronous reset, active high
	// AXI4-Lite write address
	input  wire logic [AXI_AW-1:0]       s_axi_awaddr,     // Write byte address
	input  wire logic                    s_axi_awvalid,    // Write address valid
	output logic                         s_axi_awready,    // Write address ready
	// AXI4-Lite write data
	input  wire logic [AXI_DW-1:0]       s_axi_wdata,      // Write data
	input  wire logic [AXI_DW/8-1:0]     s_axi_wstrb,      // Write byte lanes
	input  wire logic                    s_axi_wvalid,     // Write data valid
	output logic                         s_axi_wready,     // Write data ready
	// AXI4-Lite write response
	output logic [1:0]                   s_axi_bresp,      // Write response
	output logic                         s_axi_bvalid,     // Write response valid
	input  wire logic                    s_axi_bready,     // Write response ready
	// AXI4-Lite read address
	input  wire logic [AXI_AW-1:0]       s_axi_araddr,     // Read byte address
	input  wire logic                    s_axi_arvalid,    // Read address valid
	output logic                         s_axi_arready,    // Read address ready
	// AXI4-Lite read data
	output logic [AXI_DW-1:0]            s_axi_rdata,      // Read data
	output logic [1:0]                   s_axi_rresp,      // Read response
	output logic                         s_axi_rvalid,     // Read data valid
	input  wire logic                    s_axi_rready,     // Read data ready
	// Serial interface engine side
	input  wire logic [SEL_W-1:0]        sie_ep,           // Endpoint of current packet
	input  wire logic                    sie_pkt_start,    // Data PID received
	input  wire logic                    sie_byte,         // One data byte stored
	input  wire logic                    sie_pkt_ok,       // Packet stored good
	input  wire logic                    sie_pkt_bad,      // Packet dropped
	// FIFO access side
	input  wire logic [NUM_EP-1:0]       fifo_rd_stb,      // Per-endpoint byte read
	input  wire logic [NUM_EP-1:0]       bank_release,     // Per-endpoint bank done
	output logic [NUM_EP-1:0]            ep_fifo_in_reset, // Endpoint FIFO held in reset
	output logic [SEL_W-1:0]             endpoint_select,  // Selected endpoint
	output logic [NUM_EP*PTR_W-1:0]      ep_wr_ptr,        // Write pointers, packed
	output logic [NUM_EP*PTR_W-1:0]      ep_rd_ptr         // Read pointers, packed
);

	// Write channel holding registers
	logic                  aw_held;
	logic [AXI_AW-1:0]     aw_addr;
	logic                  w_held;
	logic [AXI_DW-1:0]     w_data;
	logic [AXI_DW/8-1:0]   w_strb;
	logic                  do_write;

	// Register contents and per-endpoint counts
	logic [NUM_EP-1:0]     fifo_reset;
	logic [CNT_W-1:0]      ep_count [NUM_EP];
	logic [CNT_W-1:0]      sel_count;
	logic [NUM_EP-1:0]     ep_hit;

	// Read decode
	logic [AXI_DW-1:0]     next_rdata;
	logic [1:0]            next_rresp;
	logic [7:0]            rd_idx;
	logic [7:0]            wr_idx;
	logic                  rd_mapped;
	logic                  wr_mapped;

	assign rd_idx    = s_axi_araddr[9:2];
	assign wr_idx    = aw_addr[9:2];
	assign rd_mapped = (s_axi_araddr[AXI_AW-1:10] == '0) && (s_axi_araddr[1:0] == 2'h0);
	assign wr_mapped = (aw_addr[AXI_AW-1:10] == '0) && (aw_addr[1:0] == 2'h0);

	// One write in flight: both channels are held until the response drains
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign do_write      = aw_held && w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// Capture write address
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	// Capture write data
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// Write response; count registers are read-only and refuse writes
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			if (wr_mapped && (wr_idx == IDX_EP_NUMBER || wr_idx == IDX_FIFO_RESET))
				s_axi_bresp <= RESP_OKAY;
			else
				s_axi_bresp <= RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Endpoint select; only the low field is stored
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			endpoint_select <= EP_SEL_RST;
		end else if (do_write && wr_mapped && wr_idx == IDX_EP_NUMBER && w_strb[0]) begin
			endpoint_select <= w_data[SEL_LSB +: SEL_W];
		end
	end

	// FIFO reset bits; bit seven is not stored so it can never read as one
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			fifo_reset <= FIFO_RESET_RST;
		end else if (do_write && wr_mapped && wr_idx == IDX_FIFO_RESET && w_strb[0]) begin
			fifo_reset <= w_data[FRST_LSB +: NUM_EP];
		end
	end

	// Endpoint held in reset while its bit stands; the SIE should NAK it
	assign ep_fifo_in_reset = fifo_reset;

	// Route SIE strobes to the endpoint that owns the packet
	always_comb begin
		ep_hit = '0;
		if (sie_ep < SEL_W'(NUM_EP))
			ep_hit[sie_ep] = 1'b1;
	end

	// One counter per endpoint; the big endpoints ping-pong two banks
	genvar gi;
	generate
		for (gi = 0; gi < NUM_EP; gi++) begin : g_ep
			usbepc_ep_counter #(
				.CW   (CNT_W),
				.PW   (PTR_W),
				.DUAL (DUAL_BANK_MASK[gi])
			) u_cnt (
				.sys_clk      (sys_clk),
				.rst          (rst),
				.fifo_clear   (fifo_reset[gi]),
				.pkt_start    (sie_pkt_start && ep_hit[gi]),
				.byte_stb     (sie_byte && ep_hit[gi]),
				.pkt_ok       (sie_pkt_ok && ep_hit[gi]),
				.pkt_bad      (sie_pkt_bad && ep_hit[gi]),
				.bank_release (bank_release[gi]),
				.rd_stb       (fifo_rd_stb[gi]),
				.rd_count     (ep_count[gi]),
				.wr_ptr       (ep_wr_ptr[gi*PTR_W +: PTR_W]),
				.rd_ptr       (ep_rd_ptr[gi*PTR_W +: PTR_W])
			);
		end
	endgenerate

	// Count of the selected endpoint; an out-of-range select shows zero
	always_comb begin
		sel_count = '0;
		if (endpoint_select < SEL_W'(NUM_EP))
			sel_count = ep_count[endpoint_select];
	end

	// Read mux; reserved bits above each field stay zero
	always_comb begin
		next_rdata = '0;
		next_rresp = RESP_OKAY;
		if (!rd_mapped) begin
			next_rresp = RESP_SLVERR;
		end else begin
			case (rd_idx)
				IDX_EP_NUMBER:  next_rdata[SEL_LSB +: SEL_W] = endpoint_select;
				IDX_FIFO_RESET: next_rdata[FRST_LSB +: NUM_EP] = fifo_reset;
				IDX_COUNT_LOW:  next_rdata[LOW_LSB +: LOW_W] = sel_count[7:0];
				IDX_COUNT_HIGH: next_rdata[HIGH_LSB +: HIGH_W] = sel_count[10:8];
				default:        next_rresp = RESP_SLVERR;
			endcase
		end
	end

	// Read answer one cycle after the address is taken
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= next_rdata;
			s_axi_rresp  <= next_rresp;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Helper: remember which register the answer came from; the low count
	// may show bit seven set, so the reserved-bit check needs its own flag
	logic rd_was_high;
	logic rd_was_frst;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_was_high <= 1'b0;
			rd_was_frst <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rd_was_high <= rd_mapped && rd_idx == IDX_COUNT_HIGH;
			rd_was_frst <= rd_mapped && rd_idx == IDX_FIFO_RESET;
		end
	end

	// Bus steps used by the assertions
	sequence seq_high_read;
		s_axi_arvalid && s_axi_arready && rd_mapped && rd_idx == IDX_COUNT_HIGH;
	endsequence

	sequence seq_both_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	sequence seq_reset_write;
		do_write && wr_mapped && wr_idx == IDX_FIFO_RESET && w_strb[0];
	endsequence

	sequence seq_sel_write;
		do_write && wr_mapped && wr_idx == IDX_EP_NUMBER && w_strb[0];
	endsequence

	chk_high_count_value: assert property (@(posedge sys_clk) disable iff (rst)
		seq_high_read |=> s_axi_rdata[2:0] == $past(sel_count[10:8]))
		else $error("high count read does not show count top bits");

	chk_high_upper_zero: assert property (@(posedge sys_clk) disable iff (rst)
		(s_axi_rvalid && rd_was_high) |-> s_axi_rdata[AXI_DW-1:HIGH_W] == '0)
		else $error("high count reserved bits not zero");

	chk_select_routes: assert property (@(posedge sys_clk) disable iff (rst)
		seq_sel_write |=> ##1 (endpoint_select == $past(w_data[2:0], 2)))
		else $error("endpoint select not taken from write");

	chk_reset_bits_write: assert property (@(posedge sys_clk) disable iff (rst)
		seq_reset_write |=> fifo_reset == $past(w_data[NUM_EP-1:0]))
		else $error("fifo reset bits not written");

	chk_reset_bit7_zero: assert property (@(posedge sys_clk) disable iff (rst)
		(s_axi_rvalid && rd_was_frst) |-> !s_axi_rdata[7])
		else $error("reserved bit seven read as one");

	chk_held_in_reset: assert property (@(posedge sys_clk) disable iff (rst)
		fifo_reset[0] [*2] |-> ep_count[0] == '0)
		else $error("endpoint zero count nonzero while reset");

	chk_write_answer: assert property (@(posedge sys_clk) disable iff (rst)
		seq_both_taken |-> ##2 s_axi_bvalid)
		else $error("write response late");

	chk_read_answer: assert property (@(posedge sys_clk) disable iff (rst)
		(s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
		else $error("read response late");

endmodule : usbepc_regs

/* usbepc_pkg.sv */
// Package for the endpoint byte-count and FIFO-reset register block.
// Assumes a 32-bit AXI4-Lite register bus; each register takes one word.
package usbepc_pkg;

	// Register indices; the byte address is four times the index
	localparam logic [7:0]  IDX_EP_NUMBER   = 8'hC7;
	localparam logic [7:0]  IDX_FIFO_RESET  = 8'hD5;
	localparam logic [7:0]  IDX_COUNT_LOW   = 8'hE2;
	localparam logic [7:0]  IDX_COUNT_HIGH  = 8'hE3;

	// Bus shape
	localparam int          AXI_AW          = 12;
	localparam int          AXI_DW          = 32;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	// Endpoint set and counter widths
	localparam int          NUM_EP          = 7;
	localparam int          CNT_W           = 11;
	localparam int          PTR_W           = 10;
	localparam int          SEL_W           = 3;
	localparam logic [6:0]  DUAL_BANK_MASK  = 7'h70;

	// Field positions
	localparam int          SEL_LSB         = 0;
	localparam int          LOW_LSB         = 0;
	localparam int          LOW_W           = 8;
	localparam int          HIGH_LSB        = 0;
	localparam int          HIGH_W          = 3;
	localparam int          FRST_LSB        = 0;

	// Reset values
	localparam logic [SEL_W-1:0]  EP_SEL_RST     = 3'h0;
	localparam logic [NUM_EP-1:0] FIFO_RESET_RST = 7'h00;

endpackage : usbepc_pkg

/* usbepc_ep_counter.sv */
// One endpoint's FIFO pointers and per-bank received byte counts.
// Assumes SIE strobes on the same clock, one strobe kind per cycle.
`timescale 1ns/1ps
module usbepc_ep_counter
	import usbepc_pkg::*;
#(
	parameter int   CW   = CNT_W,
	parameter int   PW   = PTR_W,
	parameter bit   DUAL = 1'b0
) (
	input  wire logic          sys_clk,      // System clock
	input  wire logic          rst,          // Synchronous reset, active high
	input  wire logic          fifo_clear,   // Endpoint FIFO held in reset
	input  wire logic          pkt_start,    // Data PID seen, packet begins
	input  wire logic          byte_stb,     // One data byte stored
	input  wire logic          pkt_ok,       // Packet stored good
	input  wire logic          pkt_bad,      // Packet dropped
	input  wire logic          bank_release, // Firmware done with read bank
	input  wire logic          rd_stb,       // Firmware read one FIFO byte
	output logic      [CW-1:0] rd_count,     // Byte count of read bank
	output logic      [PW-1:0] wr_ptr,       // FIFO write pointer
	output logic      [PW-1:0] rd_ptr        // FIFO read pointer
);

	logic [CW-1:0] run_count;
	logic [PW-1:0] pkt_base;
	logic [CW-1:0] bank_count [2];
	logic          wr_bank;
	logic          rd_bank;

	// Running count of the packet under way; a dropped packet rewinds the
	// write pointer so a half-stored packet never becomes readable
	always_ff @(posedge sys_clk) begin
		if (rst || fifo_clear) begin
			run_count <= '0;
			wr_ptr    <= '0;
			pkt_base  <= '0;
		end else if (pkt_start) begin
			run_count <= '0;
			pkt_base  <= wr_ptr;
		end else if (byte_stb) begin
			run_count <= run_count + CW'(1);
			wr_ptr    <= wr_ptr + PW'(1);
		end else if (pkt_bad) begin
			wr_ptr    <= pkt_base;
		end
	end

	// Commit the count into the write bank; ping-pong only when dual
	always_ff @(posedge sys_clk) begin
		if (rst || fifo_clear) begin
			bank_count[0] <= '0;
			bank_count[1] <= '0;
			wr_bank       <= 1'b0;
		end else if (pkt_ok) begin
			bank_count[wr_bank] <= run_count;
			wr_bank             <= DUAL ? ~wr_bank : 1'b0;
		end
	end

	// Read side bank and pointer
	always_ff @(posedge sys_clk) begin
		if (rst || fifo_clear) begin
			rd_bank <= 1'b0;
			rd_ptr  <= '0;
		end else begin
			if (bank_release && DUAL)
				rd_bank <= ~rd_bank;
			if (rd_stb)
				rd_ptr <= rd_ptr + PW'(1);
		end
	end

	assign rd_count = bank_count[rd_bank];

	// Clearing empties every bank and both pointers
	chk_clear_empties: assert property (@(posedge sys_clk) disable iff (rst)
		fifo_clear |=> (bank_count[0] == '0 && bank_count[1] == '0 &&
			wr_ptr == '0 && rd_ptr == '0))
		else $error("fifo clear left state behind");

	// A committed packet count equals the bytes counted since the PID
	chk_count_commit: assert property (@(posedge sys_clk) disable iff (rst)
		(pkt_ok && !fifo_clear) |=> bank_count[$past(wr_bank)] == $past(run_count))
		else $error("committed count differs from bytes received");

	// Bytes offered during reset never move the pointer
	chk_reset_blocks: assert property (@(posedge sys_clk) disable iff (rst)
		(fifo_clear && byte_stb) |=> (wr_ptr == '0 && run_count == '0))
		else $error("byte accepted while fifo in reset");

endmodule : usbepc_ep_counter

/* usbepc_host_model.sv */
// Far-side model: the USB host's data packets as seen through the SIE strobes.
// Assumes the same sys_clk as the register block; strobes change after rising edges.
`timescale 1ns/1ps
module usbepc_host_model
	import usbepc_pkg::*;
(
	input  wire logic              sys_clk,       // System clock
	output logic      [SEL_W-1:0]  sie_ep,        // Endpoint of current packet
	output logic                   sie_pkt_start, // Data PID received
	output logic                   sie_byte,      // One data byte stored
	output logic                   sie_pkt_ok,    // Packet stored good
	output logic                   sie_pkt_bad    // Packet dropped
);
	// Bus idle at time zero
	initial begin
		sie_ep = 3'h0;
		sie_pkt_start = 1'b0;
		sie_byte = 1'b0;
		sie_pkt_ok = 1'b0;
		sie_pkt_bad = 1'b0;
	end

	// One packet: data PID, n payload bytes, then good or bad end; gap slows the bytes
	task automatic send_pkt(input logic [SEL_W-1:0] ep, input int n, input logic good,
			input int gap);
		@(posedge sys_clk);
		sie_ep <= ep;
		sie_pkt_start <= 1'b1; // Only bytes after the data PID are counted
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			sie_pkt_start <= 1'b0;
			sie_byte <= 1'b1;
			repeat (gap) begin
				@(posedge sys_clk);
				sie_byte <= 1'b0;
			end
		end
		@(posedge sys_clk);
		sie_pkt_start <= 1'b0;
		sie_byte <= 1'b0;
		sie_pkt_ok <= good;
		sie_pkt_bad <= !good;
		@(posedge sys_clk);
		sie_pkt_ok <= 1'b0;
		sie_pkt_bad <= 1'b0;
		// Endpoint lines no longer valid, so show something other than the last value
		sie_ep <= ~ep;
	endtask : send_pkt
endmodule : usbepc_host_model

/* test_usbepc_regs.sv */
// Self-checking bench for the byte-count and FIFO-reset registers over AXI4-Lite.
// Assumes the host model drives the SIE side; FIFO reads and bank releases are bench strobes.
`timescale 1ns/1ps
module test_usbepc_regs;
	import usbepc_pkg::*;
	localparam logic [11:0] A_SEL = {2'h0, IDX_EP_NUMBER, 2'h0};
	localparam logic [11:0] A_RST = {2'h0, IDX_FIFO_RESET, 2'h0};
	localparam logic [11:0] A_LO  = {2'h0, IDX_COUNT_LOW, 2'h0};
	localparam logic [11:0] A_HI  = {2'h0, IDX_COUNT_HIGH, 2'h0};

	logic                    sys_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic                    s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic                    s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [AXI_AW-1:0]       s_axi_awaddr, s_axi_araddr;
	logic [AXI_DW-1:0]       s_axi_wdata, s_axi_rdata, rd_data;
	logic [AXI_DW/8-1:0]     s_axi_wstrb;
	logic [1:0]              s_axi_bresp, s_axi_rresp, rsp;
	logic [SEL_W-1:0]        sie_ep, endpoint_select;
	logic                    sie_pkt_start, sie_byte, sie_pkt_ok, sie_pkt_bad;
	logic [NUM_EP-1:0]       fifo_rd_stb, bank_release, ep_fifo_in_reset;
	logic [NUM_EP*PTR_W-1:0] ep_wr_ptr, ep_rd_ptr;
	logic [CNT_W-1:0]        len [NUM_EP];
	int                      n_fail, n_tests;

	usbepc_regs usbepc_regs_inst (
		.sys_clk(sys_clk), .rst(rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sie_ep(sie_ep),
		.sie_pkt_start(sie_pkt_start), .sie_byte(sie_byte), .sie_pkt_ok(sie_pkt_ok),
		.sie_pkt_bad(sie_pkt_bad), .fifo_rd_stb(fifo_rd_stb), .bank_release(bank_release),
		.ep_fifo_in_reset(ep_fifo_in_reset), .endpoint_select(endpoint_select),
		.ep_wr_ptr(ep_wr_ptr), .ep_rd_ptr(ep_rd_ptr)
	);

	usbepc_host_model usbepc_host_model_inst (
		.sys_clk(sys_clk), .sie_ep(sie_ep), .sie_pkt_start(sie_pkt_start),
		.sie_byte(sie_byte), .sie_pkt_ok(sie_pkt_ok), .sie_pkt_bad(sie_pkt_bad)
	);

	// 200 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Write: address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [11:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd_data = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	// Select an endpoint, then read both halves of its byte count
	task automatic rd_cnt(input logic [SEL_W-1:0] ep, input logic [CNT_W-1:0] n);
		axi_wr(A_SEL, 32'(ep));
		chk(32'(endpoint_select), 32'(ep));
		axi_rd(A_LO);
		chk(rd_data, {24'h0, n[7:0]});
		axi_rd(A_HI);
		chk(rd_data, {29'h0, n[10:8]});
		chk(32'(rsp), 32'(RESP_OKAY));
	endtask : rd_cnt

	task automatic end_of_test;
		if (n_fail == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test

	// Watchdog: the whole sequence needs well under 10k cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		end_of_test();
	end

	initial begin
		rst = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 12'h000;
		s_axi_araddr = 12'h000;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		fifo_rd_stb = 7'h00;
		bank_release = 7'h00;
		n_fail = 0;
		n_tests = 0;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		// Reset values
		axi_rd(A_RST);
		chk(rd_data, 32'h0);
		axi_rd(A_HI);
		chk(rd_data, 32'h0);
		// Set every reset bit; reserved bit 7 is left clear, firmware never sets it
		axi_wr(A_RST, 32'h7F);
		axi_rd(A_RST);
		chk(rd_data, 32'h7F);
		chk(32'(ep_fifo_in_reset), 32'h7F);
		// Traffic to a FIFO held in reset is not stored
		usbepc_host_model_inst.send_pkt(3'h1, 20, 1'b1, 0);
		rd_cnt(3'h1, 11'h0);
		axi_wr(A_RST, 32'h00);
		chk(32'(ep_fifo_in_reset), 32'h0);
		// One packet per endpoint, lengths spanning every high-count value up to 4
		for (int e = 0; e < NUM_EP; e++) begin
			len[e] = 11'(9 + e * 170);
			usbepc_host_model_inst.send_pkt(3'(e), int'(len[e]), 1'b1, 0);
		end
		for (int e = 0; e < NUM_EP; e++) rd_cnt(3'(e), len[e]);
		// A dropped packet from a slow host leaves the stored count alone
		usbepc_host_model_inst.send_pkt(3'h0, 5, 1'b0, 2);
		rd_cnt(3'h0, len[0]);
		chk(32'(ep_wr_ptr[0 +: PTR_W]), 32'h9);
		// Second packet on a two-bank endpoint lands in the other bank
		usbepc_host_model_inst.send_pkt(3'h4, 40, 1'b1, 0);
		rd_cnt(3'h4, len[4]);
		@(posedge sys_clk);
		bank_release <= 7'h10;
		@(posedge sys_clk);
		bank_release <= 7'h00;
		rd_cnt(3'h4, 11'h028);
		// Move endpoint 3's read pointer so the reset has something to clear
		@(posedge sys_clk);
		fifo_rd_stb <= 7'h08;
		@(posedge sys_clk);
		fifo_rd_stb <= 7'h00;
		@(posedge sys_clk);
		chk(32'(ep_rd_ptr[3*PTR_W +: PTR_W]), 32'h1);
		chk(32'(ep_wr_ptr[3*PTR_W +: PTR_W]), 32'h207);
		// Resetting endpoint 3 clears its pointers and count, others untouched
		axi_wr(A_RST, 32'h08);
		@(posedge sys_clk);
		chk(32'(ep_wr_ptr[3*PTR_W +: PTR_W]), 32'h0);
		chk(32'(ep_rd_ptr[3*PTR_W +: PTR_W]), 32'h0);
		rd_cnt(3'h3, 11'h0);
		rd_cnt(3'h2, len[2]);
		axi_wr(A_RST, 32'h00);
		// Count register is read-only; a write is refused and changes nothing
		axi_wr(A_HI, 32'h07);
		chk(32'(rsp), 32'(RESP_SLVERR));
		rd_cnt(3'h2, len[2]);
		// A write without its low byte lane is answered but changes nothing
		s_axi_wstrb <= 4'hE;
		axi_wr(A_SEL, 32'h5);
		s_axi_wstrb <= 4'hF;
		chk(32'(rsp), 32'(RESP_OKAY));
		chk(32'(endpoint_select), 32'h2);
		// Unmapped address
		axi_rd(12'h400);
		chk(32'(rsp), 32'(RESP_SLVERR));
		chk(rd_data, 32'h0);
		end_of_test();
	end
endmodule : test_usbepc_regs
